// *** include/irq_prio_map.vh ***
// Constants for the four-level interrupt priority controller
`ifndef IRQ_PRIO_MAP_VH
`define IRQ_PRIO_MAP_VH

`define NUM_SRC 14
// Source index equals arbitration rank minus one
`define SRC_EXT0 0
`define SRC_BOD 1
`define SRC_WDT 2
`define SRC_TMR0 3
`define SRC_TWI 4
`define SRC_ADC 5
`define SRC_EXT1 6
`define SRC_KBD 7
`define SRC_TMR1 8
`define SRC_SER 9
`define SRC_BRK 10
`define SRC_SPI 11
`define SRC_TMR2 12
`define SRC_CAP 13

`define VEC_EXT0 16'h0003
`define VEC_TMR0 16'h000b
`define VEC_EXT1 16'h0013
`define VEC_TMR1 16'h001b
`define VEC_SER 16'h0023
`define VEC_TMR2 16'h002b
`define VEC_TWI 16'h0033
`define VEC_KBD 16'h003b
`define VEC_BOD 16'h0043
`define VEC_SPI 16'h004b
`define VEC_WDT 16'h0053
`define VEC_ADC 16'h005b
`define VEC_CAP 16'h0063
`define VEC_BRK 16'h0073

// Register bit positions
`define BASE_GLB_EN 7
`define BASE_EXT0_EN 0
`define BASE_TMR0_EN 1
`define BASE_EXT1_EN 2
`define BASE_TMR1_EN 3
`define BASE_SER_EN 4
`define BASE_BOD_EN 5
`define BASE_ADC_EN 6
`define BASE_CAP_PRIO 7
`define EXT_TWI 0
`define EXT_KBD 1
`define EXT_CAP_EN 2
`define EXT_WDT 4
`define EXT_BRK 5
`define EXT_SPI 6
`define EXT_TMR2 7

`define CALL_CYCLES 3'h4
`define SP_RESET 8'h07

`endif

// *** rtl/irq_arbiter.v ***
// Priority resolver: highest level first, fixed rank within a level
`timescale 1ns/1ps
`include "irq_prio_map.vh"
module irq_arbiter (
  input wire [13:0] req_i,
  input wire [27:0] lvl_i,
  output reg found_o,
  output reg [3:0] idx_o,
  output reg [1:0] lvl_o
);
  integer i;
  integer l;
  reg done;

  always @* begin
    found_o = 1'b0;
    idx_o = 4'h0;
    lvl_o = 2'h0;
    done = 1'b0;
    for (l = 3; l >= 0; l = l - 1) begin
      for (i = 0; i < `NUM_SRC; i = i + 1) begin
        if (!done && req_i[i] && lvl_i[2*i +: 2] == l[1:0]) begin
          done = 1'b1;
          found_o = 1'b1;
          idx_o = i[3:0];
          lvl_o = l[1:0];
        end
      end
    end
  end
endmodule // irq_arbiter

// *** rtl/irq_edge_detect.v ***
// External request input synchroniser and falling edge detector
`timescale 1ns/1ps
module irq_edge_detect (
  input wire ref_clk_i,
  input wire nrst_i,
  input wire mc_tick_i,
  input wire pin_i,
  output wire fall_o
);
  reg sync1_q;
  reg sync2_q;
  reg prev_q;

  // Two flops for the asynchronous pin, then one sample per machine cycle
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
      prev_q <= 1'b1;
    end else begin
      sync1_q <= pin_i;
      sync2_q <= sync1_q;
      if (mc_tick_i) begin
        prev_q <= sync2_q;
      end
    end
  end

  // High in one machine cycle, low in the next
  assign fall_o = mc_tick_i & prev_q & ~sync2_q;
endmodule // irq_edge_detect

// *** rtl/irq_prio_ctrl.v ***
// Four-level interrupt priority and vectoring controller
`timescale 1ns/1ps
`include "irq_prio_map.vh"
module irq_prio_ctrl (
  input wire ref_clk_i,
  input wire nrst_i,
  input wire mc_tick_i,
  input wire last_cycle_i,
  input wire cfg_write_i,
  input wire isr_exit_i,
  input wire ret_i,
  input wire [7:0] base_enable_reg_i,
  input wire [7:0] ext_enable_reg_i,
  input wire [7:0] base_prio_low_reg_i,
  input wire [7:0] base_prio_high_reg_i,
  input wire [7:0] ext_prio_low_reg_i,
  input wire [7:0] ext_prio_high_reg_i,
  input wire [15:0] pc_i,
  input wire [15:0] pop_pc_i,
  input wire ext0_pin_n_i,
  input wire ext1_pin_n_i,
  input wire ext0_edge_mode_i,
  input wire ext1_edge_mode_i,
  input wire ext0_sw_set_i,
  input wire ext0_sw_clr_i,
  input wire ext1_sw_set_i,
  input wire ext1_sw_clr_i,
  input wire timer0_ovf_i,
  input wire timer1_ovf_i,
  input wire timer0_sw_clr_i,
  input wire timer1_sw_clr_i,
  input wire brownout_flag_i,
  input wire watchdog_flag_i,
  input wire twowire_timeout_flag_i,
  input wire converter_done_flag_i,
  input wire [7:0] keypad_flags_i,
  input wire serial_tx_flag_i,
  input wire serial_rx_flag_i,
  input wire brake_flag_i,
  input wire sp_done_flag_i,
  input wire sp_mode_fault_flag_i,
  input wire sp_overrun_flag_i,
  input wire timer2_match_flag_i,
  input wire [2:0] capture_flags_i,
  input wire internal_rc_oscillator_i,
  output reg ext0_request_flag_o,
  output reg ext1_request_flag_o,
  output reg timer0_overflow_flag_o,
  output reg timer1_overflow_flag_o,
  output reg call_busy_o,
  output reg push_o,
  output reg [15:0] push_data_o,
  output reg pc_load_o,
  output reg [15:0] pc_load_val_o,
  output reg [3:0] in_service_o,
  output reg [3:0] active_src_o,
  output reg wake_o
);
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function [15:0] vec_of;
    input [3:0] idx;
    begin
      case (idx)
        4'h0: vec_of = `VEC_EXT0;
        4'h1: vec_of = `VEC_BOD;
        4'h2: vec_of = `VEC_WDT;
        4'h3: vec_of = `VEC_TMR0;
        4'h4: vec_of = `VEC_TWI;
        4'h5: vec_of = `VEC_ADC;
        4'h6: vec_of = `VEC_EXT1;
        4'h7: vec_of = `VEC_KBD;
        4'h8: vec_of = `VEC_TMR1;
        4'h9: vec_of = `VEC_SER;
        4'ha: vec_of = `VEC_BRK;
        4'hb: vec_of = `VEC_SPI;
        4'hc: vec_of = `VEC_TMR2;
        default: vec_of = `VEC_CAP;
      endcase
    end
  endfunction

  // One-hot mask of the highest set in-service bit, 0 when none
  function [3:0] top_bit;
    input [3:0] v;
    begin
      top_bit = v[3] ? 4'h8 : v[2] ? 4'h4 : v[1] ? 4'h2 : v[0] ? 4'h1 : 4'h0;
    end
  endfunction

  // ---------------------------------------------------------------
  // Synchronise asynchronous flag inputs
  // ---------------------------------------------------------------
  wire [13:0] raw_flags;
  reg [13:0] s1_q;
  reg [13:0] s2_q;
  reg [13:0] smp_q;
  wire ext0_fall;
  wire ext1_fall;

  irq_edge_detect u_ext0 (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .mc_tick_i(mc_tick_i),
    .pin_i(ext0_pin_n_i),
    .fall_o(ext0_fall)
  );

  irq_edge_detect u_ext1 (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .mc_tick_i(mc_tick_i),
    .pin_i(ext1_pin_n_i),
    .fall_o(ext1_fall)
  );

  // Level-mode external pins are passed through the same sync chain
  assign raw_flags = {
    |capture_flags_i,
    timer2_match_flag_i,
    sp_done_flag_i | sp_mode_fault_flag_i | sp_overrun_flag_i,
    brake_flag_i,
    serial_tx_flag_i | serial_rx_flag_i,
    1'b0,
    |keypad_flags_i,
    ~ext1_pin_n_i,
    converter_done_flag_i,
    twowire_timeout_flag_i,
    1'b0,
    watchdog_flag_i,
    brownout_flag_i,
    ~ext0_pin_n_i
  };

  // ---------------------------------------------------------------
  // Hardware-cleared flags (external request flags only in edge mode; in level mode they follow the pin)
  // ---------------------------------------------------------------
  reg [2:0] state_q;
  reg [2:0] cnt_q;
  reg [3:0] win_idx_q;
  reg [1:0] win_lvl_q;
  wire ack;
  wire ack_ext0;
  wire ack_ext1;

  localparam ST_IDLE = 3'h0;
  localparam ST_CALL = 3'h1;

  assign ack = (state_q == ST_CALL) && (cnt_q == 3'h0) && mc_tick_i;
  assign ack_ext0 = ack && win_idx_q == `SRC_EXT0;
  assign ack_ext1 = ack && win_idx_q == `SRC_EXT1;

  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_q <= 14'h0000;
      s2_q <= 14'h0000;
      ext0_request_flag_o <= 1'b0;
      ext1_request_flag_o <= 1'b0;
      timer0_overflow_flag_o <= 1'b0;
      timer1_overflow_flag_o <= 1'b0;
    end else begin
      s1_q <= raw_flags;
      s2_q <= s1_q;
      // Set wins over any clear in the same cycle
      if (ext0_edge_mode_i) begin
        if (ext0_fall || ext0_sw_set_i)
          ext0_request_flag_o <= 1'b1;
        else if (ack_ext0 || ext0_sw_clr_i)
          ext0_request_flag_o <= 1'b0;
      end else begin
        ext0_request_flag_o <= s2_q[`SRC_EXT0] | ext0_sw_set_i;
      end
      if (ext1_edge_mode_i) begin
        if (ext1_fall || ext1_sw_set_i)
          ext1_request_flag_o <= 1'b1;
        else if (ack_ext1 || ext1_sw_clr_i)
          ext1_request_flag_o <= 1'b0;
      end else begin
        ext1_request_flag_o <= s2_q[`SRC_EXT1] | ext1_sw_set_i;
      end
      if (timer0_ovf_i)
        timer0_overflow_flag_o <= 1'b1;
      else if ((ack && win_idx_q == `SRC_TMR0) || timer0_sw_clr_i)
        timer0_overflow_flag_o <= 1'b0;
      if (timer1_ovf_i)
        timer1_overflow_flag_o <= 1'b1;
      else if ((ack && win_idx_q == `SRC_TMR1) || timer1_sw_clr_i)
        timer1_overflow_flag_o <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Sampling, enables and levels
  // ---------------------------------------------------------------
  wire [13:0] flags_now;
  wire [13:0] enables;
  wire [27:0] levels;
  wire [13:0] req;
  wire found;
  wire [3:0] win_idx;
  wire [1:0] win_lvl;
  wire [3:0] isr_top;
  wire blocked;
  wire take;
  genvar g;

  // other flags merely pass through; only software clears them
  assign flags_now = {s2_q[13:10], s2_q[9], timer1_overflow_flag_o,
    s2_q[7], ext1_request_flag_o, s2_q[5:4], timer0_overflow_flag_o,
    s2_q[2:1], ext0_request_flag_o};

  assign enables = {
    ext_enable_reg_i[`EXT_CAP_EN],
    ext_enable_reg_i[`EXT_TMR2],
    ext_enable_reg_i[`EXT_SPI],
    ext_enable_reg_i[`EXT_BRK],
    base_enable_reg_i[`BASE_SER_EN],
    base_enable_reg_i[`BASE_TMR1_EN],
    ext_enable_reg_i[`EXT_KBD],
    base_enable_reg_i[`BASE_EXT1_EN],
    base_enable_reg_i[`BASE_ADC_EN],
    ext_enable_reg_i[`EXT_TWI],
    base_enable_reg_i[`BASE_TMR0_EN],
    ext_enable_reg_i[`EXT_WDT],
    base_enable_reg_i[`BASE_BOD_EN],
    base_enable_reg_i[`BASE_EXT0_EN]
  };

  // High bit from the high register, low bit from the low register
  `define PR(r, b) {base_prio_high_reg_i[b], base_prio_low_reg_i[b]}
  `define PX(b) {ext_prio_high_reg_i[b], ext_prio_low_reg_i[b]}
  assign levels = {
    `PR(0, `BASE_CAP_PRIO), `PX(7), `PX(6), `PX(5),
    `PR(0, 4), `PR(0, 3), `PX(1), `PR(0, 2),
    `PR(0, 6), `PX(0), `PR(0, 1), `PX(4), `PR(0, 5), `PR(0, 0)
  };

  // Per-machine-cycle snapshot; nothing survives a denial
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i)
      smp_q <= 14'h0000;
    else if (mc_tick_i)
      smp_q <= flags_now;
  end

  generate
    for (g = 0; g < `NUM_SRC; g = g + 1) begin : g_req
      assign req[g] = smp_q[g] & enables[g] &
        base_enable_reg_i[`BASE_GLB_EN];
    end
  endgenerate

  irq_arbiter u_arb (
    .req_i(req),
    .lvl_i(levels),
    .found_o(found),
    .idx_o(win_idx),
    .lvl_o(win_lvl)
  );

  assign isr_top = top_bit(in_service_o);
  // Preempt only when strictly above every level in service
  assign blocked = (isr_top >> win_lvl) != 4'h0;
  assign take = mc_tick_i && found && !blocked && last_cycle_i
    && !cfg_write_i && !isr_exit_i && state_q == ST_IDLE;

  // ---------------------------------------------------------------
  // Vector call sequencer and in-service tracking
  // ---------------------------------------------------------------
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= ST_IDLE;
      cnt_q <= 3'h0;
      win_idx_q <= 4'h0;
      win_lvl_q <= 2'h0;
      call_busy_o <= 1'b0;
      push_o <= 1'b0;
      push_data_o <= 16'h0000;
      pc_load_o <= 1'b0;
      pc_load_val_o <= 16'h0000;
      in_service_o <= 4'h0;
      active_src_o <= 4'h0;
    end else begin
      push_o <= 1'b0;
      pc_load_o <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (take) begin
            state_q <= ST_CALL;
            cnt_q <= `CALL_CYCLES - 3'h1;
            win_idx_q <= win_idx;
            win_lvl_q <= win_lvl;
            call_busy_o <= 1'b1;
            push_o <= 1'b1;
            push_data_o <= pc_i;
          end else if (mc_tick_i && isr_exit_i) begin
            pc_load_o <= 1'b1;
            pc_load_val_o <= pop_pc_i;
            in_service_o <= in_service_o & ~top_bit(in_service_o);
          end else if (mc_tick_i && ret_i) begin
            pc_load_o <= 1'b1;
            pc_load_val_o <= pop_pc_i;
          end
        end
        ST_CALL: begin
          if (mc_tick_i) begin
            if (cnt_q == 3'h0) begin
              state_q <= ST_IDLE;
              call_busy_o <= 1'b0;
              pc_load_o <= 1'b1;
              pc_load_val_o <= vec_of(win_idx_q);
              in_service_o <= in_service_o | (4'h1 << win_lvl_q);
              active_src_o <= win_idx_q;
            end else begin
              cnt_q <= cnt_q - 3'h1;
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Power-down wake
  // ---------------------------------------------------------------
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i)
      wake_o <= 1'b0;
    else
      wake_o <= req[`SRC_EXT0] | req[`SRC_EXT1] | req[`SRC_BOD] |
        req[`SRC_WDT] | req[`SRC_KBD] |
        (req[`SRC_ADC] & internal_rc_oscillator_i);
  end
  `undef PR
  `undef PX
endmodule // irq_prio_ctrl

// *** verif/core_seq_model.sv ***
// Behavioural model of the core sequencer and its stack
`timescale 1ns/1ps
module core_seq_model (
  input wire ref_clk_i,
  input wire nrst_i,
  input wire call_busy_i,
  input wire push_i,
  input wire [15:0] push_data_i,
  input wire pc_load_i,
  input wire [15:0] pc_load_val_i,
  output reg mc_tick_o,
  output reg [15:0] pc_o,
  output wire [15:0] pop_pc_o
);
  reg [15:0] stk_q [0:7];
  reg [2:0] sp_q;
  reg [1:0] ph_q;
  reg busy_q;
  integer k;
  assign pop_pc_o = stk_q[sp_q];
  // Four clocks to a machine cycle; stack filled so a stray pop is defined
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ph_q <= 2'h0;
      mc_tick_o <= 1'b0;
      pc_o <= 16'h0100;
      sp_q <= 3'h0;
      busy_q <= 1'b0;
      for (k = 0; k < 8; k = k + 1)
        stk_q[k] <= {13'h0040, k[2:0]};
    end else begin
      ph_q <= ph_q + 2'h1;
      mc_tick_o <= (ph_q == 2'h2);
      busy_q <= call_busy_i;
      if (pc_load_i)
        pc_o <= pc_load_val_i;
      else if (mc_tick_o)
        pc_o <= pc_o + 16'h0001;
      if (push_i) begin
        sp_q <= sp_q + 3'h1;
        stk_q[sp_q + 3'h1] <= push_data_i;
      end else if (pc_load_i && !busy_q)
        sp_q <= sp_q - 3'h1;
    end
  end
endmodule // core_seq_model

// *** verif/irq_prio_ctrl_props.sv ***
// Concurrent checks on the interrupt priority controller ports
`timescale 1ns/1ps
`include "irq_prio_map.vh"
module irq_prio_ctrl_props (
  input wire ref_clk_i,
  input wire nrst_i,
  input wire mc_tick_i,
  input wire last_cycle_i,
  input wire cfg_write_i,
  input wire isr_exit_i,
  input wire ret_i,
  input wire [7:0] base_enable_reg_i,
  input wire [15:0] pop_pc_i,
  input wire [15:0] pc_i,
  input wire timer0_overflow_flag_o,
  input wire timer1_overflow_flag_o,
  input wire call_busy_o,
  input wire push_o,
  input wire [15:0] push_data_o,
  input wire pc_load_o,
  input wire [15:0] pc_load_val_o,
  input wire [3:0] in_service_o,
  input wire [3:0] active_src_o
);
  localparam [111:0] VT = 112'h632b4b73231b3b135b330b534303;
  reg [2:0] n_q;
  wire [3:0] drop_w;
  // In-service set with its highest level removed
  assign drop_w = in_service_o[3] ? {1'b0, in_service_o[2:0]} :
    in_service_o[2] ? {2'h0, in_service_o[1:0]} :
    in_service_o[1] ? {3'h0, in_service_o[0]} : 4'h0;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  // Machine cycles spent inside one call
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i)
      n_q <= 3'h0;
    else if (!call_busy_o)
      n_q <= 3'h0;
    else if (mc_tick_i)
      n_q <= n_q + 3'h1;
  end
  sequence s_take;
    $rose(call_busy_o);
  endsequence
  sequence s_load;
    pc_load_o && $past(call_busy_o);
  endsequence
  a_call_pushes:
    assert property (s_take |-> ##[0:1] push_o)
    else $error("call without push");
  a_push_pc:
    assert property (push_o |-> push_data_o == $past(pc_i))
    else $error("pushed value is not the program counter");
  a_take_gate:
    assert property (s_take |-> $past(mc_tick_i) && $past(last_cycle_i) &&
      !$past(cfg_write_i) && !$past(isr_exit_i) &&
      $past(base_enable_reg_i[7]))
    else $error("call taken while blocked");
  a_call_four:
    assert property ($fell(call_busy_o) |-> pc_load_o && n_q == 3'h4)
    else $error("call length wrong");
  a_vec_addr:
    assert property (s_load |->
      pc_load_val_o == {8'h00, VT[active_src_o*8 +: 8]})
    else $error("wrong vector");
  a_timer_clear:
    assert property (s_load |->
      !(active_src_o == `SRC_TMR0 && timer0_overflow_flag_o) &&
      !(active_src_o == `SRC_TMR1 && timer1_overflow_flag_o))
    else $error("timer flag kept");
  a_level_rise:
    assert property (s_load |-> in_service_o > $past(in_service_o))
    else $error("call without higher level");
  a_exit_pop:
    assert property (mc_tick_i && isr_exit_i && !call_busy_o |=> pc_load_o &&
      pc_load_val_o == $past(pop_pc_i) && in_service_o == $past(drop_w))
    else $error("return from interrupt wrong");
  a_ret_keeps:
    assert property (mc_tick_i && ret_i && !isr_exit_i && !last_cycle_i &&
      !call_busy_o |=> pc_load_o && pc_load_val_o == $past(pop_pc_i) &&
      in_service_o == $past(in_service_o))
    else $error("plain return changed level");
endmodule // irq_prio_ctrl_props

bind irq_prio_ctrl irq_prio_ctrl_props irq_prio_ctrl_props_i (
  .ref_clk_i, .nrst_i, .mc_tick_i, .last_cycle_i, .cfg_write_i, .isr_exit_i,
  .ret_i, .base_enable_reg_i, .pop_pc_i, .pc_i, .timer0_overflow_flag_o,
  .timer1_overflow_flag_o, .call_busy_o, .push_o, .push_data_o, .pc_load_o,
  .pc_load_val_o, .in_service_o, .active_src_o);

// *** verif/irq_prio_ctrl_tb.sv ***
// Self-checking testbench for the interrupt priority controller
`timescale 1ns/1ps
`include "irq_prio_map.vh"
module irq_prio_ctrl_tb;
  localparam [55:0] EN = 56'hafed4392681c50;
  localparam [111:0] VT = 112'h632b4b73231b3b135b330b534303;
  localparam [13:0] WAKE = 14'h00c7;
  reg ref_clk_i = 1'b0;
  reg nrst_i = 1'b0;
  reg last_cycle_i = 1'b0;
  reg cfg_write_i = 1'b0;
  reg isr_exit_i = 1'b0;
  reg ret_i = 1'b0;
  reg ext0_edge_mode_i = 1'b1;
  reg internal_rc_oscillator_i = 1'b0;
  reg [7:0] be = 8'h00, ee = 8'h00, bl = 8'h00;
  reg [7:0] bh = 8'h00, el = 8'h00, eh = 8'h00;
  reg [13:0] fl = 14'h0000;
  reg [13:0] clr = 14'h0000;
  integer n_errors = 0;
  integer compares = 0;
  integer cyc = 0;
  wire mc_tick_i;
  wire [15:0] pc_i, pop_pc_i, push_data_o, pc_load_val_o;
  wire ext0_request_flag_o, ext1_request_flag_o;
  wire timer0_overflow_flag_o, timer1_overflow_flag_o;
  wire call_busy_o, push_o, pc_load_o, wake_o;
  wire [3:0] in_service_o, active_src_o;
  irq_prio_ctrl irq_prio_ctrl_i (
    .ref_clk_i, .nrst_i, .mc_tick_i, .last_cycle_i, .cfg_write_i,
    .isr_exit_i, .ret_i, .base_enable_reg_i(be), .ext_enable_reg_i(ee),
    .base_prio_low_reg_i(bl), .base_prio_high_reg_i(bh),
    .ext_prio_low_reg_i(el), .ext_prio_high_reg_i(eh), .pc_i, .pop_pc_i,
    .ext0_pin_n_i(!fl[0]), .ext1_pin_n_i(!fl[6]), .ext0_edge_mode_i,
    .ext1_edge_mode_i(ext0_edge_mode_i), .ext0_sw_set_i(1'b0),
    .ext0_sw_clr_i(clr[0]),
    .ext1_sw_set_i(1'b0), .ext1_sw_clr_i(clr[6]), .timer0_ovf_i(fl[3]),
    .timer1_ovf_i(fl[8]), .timer0_sw_clr_i(clr[3]), .timer1_sw_clr_i(clr[8]),
    .brownout_flag_i(fl[1]), .watchdog_flag_i(fl[2]),
    .twowire_timeout_flag_i(fl[4]), .converter_done_flag_i(fl[5]),
    .keypad_flags_i({7'h00, fl[7]}), .serial_tx_flag_i(fl[9]),
    .serial_rx_flag_i(fl[9]), .brake_flag_i(fl[10]), .sp_done_flag_i(fl[11]),
    .sp_mode_fault_flag_i(fl[11]), .sp_overrun_flag_i(fl[11]),
    .timer2_match_flag_i(fl[12]), .capture_flags_i({2'h0, fl[13]}),
    .internal_rc_oscillator_i, .ext0_request_flag_o, .ext1_request_flag_o,
    .timer0_overflow_flag_o, .timer1_overflow_flag_o, .call_busy_o, .push_o,
    .push_data_o, .pc_load_o, .pc_load_val_o, .in_service_o, .active_src_o,
    .wake_o);
  core_seq_model core_seq_model_i (
    .ref_clk_i, .nrst_i, .call_busy_i(call_busy_o), .push_i(push_o),
    .push_data_i(push_data_o), .pc_load_i(pc_load_o),
    .pc_load_val_i(pc_load_val_o), .mc_tick_o(mc_tick_i), .pc_o(pc_i),
    .pop_pc_o(pop_pc_i));
  // --------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------
  task conclude;
    begin
      $display("compares %0d n_errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  task step(input integer n);
    begin
      repeat (n) @(posedge ref_clk_i);
      #1;
    end
  endtask
  task chk(input [63:0] nm, input [15:0] e, input [15:0] g);
    begin
      compares = compares + 1;
      if (g !== e) begin
        n_errors = n_errors + 1;
        $display("MISMATCH %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task wait_load(output got);
    integer k;
    begin
      got = 1'b0;
      for (k = 0; k < 120 && !got; k = k + 1) begin
        step(1);
        got = (pc_load_o === 1'b1);
      end
    end
  endtask
  // Timer inputs are pulses, so a held flag would defeat the hardware clear
  task set_flag(input [3:0] i, input v);
    begin
      fl[i] = v;
      clr[i] = !v;
      step(1);
      clr[i] = 1'b0;
      if (i == `SRC_TMR0 || i == `SRC_TMR1)
        fl[i] = 1'b0;
    end
  endtask
  task src_cfg(input [3:0] i, input [1:0] l);
    reg [3:0] e;
    begin
      e = EN[i*4 +: 4];
      be[7] = 1'b1;
      if (e[3])
        ee[e[2:0]] = 1'b1;
      else
        be[e[2:0]] = 1'b1;
      if (i == `SRC_CAP)
        e = 4'h7;
      if (e[3])
        {eh[e[2:0]], el[e[2:0]]} = l;
      else
        {bh[e[2:0]], bl[e[2:0]]} = l;
    end
  endtask
  task do_ret(input r);
    begin
      isr_exit_i = r;
      ret_i = !r;
      while (mc_tick_i !== 1'b1)
        step(1);
      step(1);
      isr_exit_i = 1'b0;
      ret_i = 1'b0;
    end
  endtask
  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  task t_all;
    integer i;
    reg got;
    begin
      for (i = 0; i < 14; i = i + 1) begin
        {be, ee, bl, bh, el, eh} = 48'h0;
        src_cfg(i[3:0], 2'h0);
        set_flag(i[3:0], 1'b1);
        last_cycle_i = 1'b1;
        wait_load(got);
        chk("vector", {8'h00, VT[i*8 +: 8]}, pc_load_val_o);
        chk("source", i[15:0], active_src_o);
        chk("inserv", 16'h0001, in_service_o);
        chk("hwclr", 16'h0000, {ext0_request_flag_o, ext1_request_flag_o,
          timer0_overflow_flag_o, timer1_overflow_flag_o});
        last_cycle_i = 1'b0;
        set_flag(i[3:0], 1'b0);
        do_ret(1'b1);
        chk("inserv", 16'h0000, in_service_o);
      end
    end
  endtask
  task t_prio;
    reg got;
    begin
      {be, ee, bl, bh, el, eh} = 48'h0;
      src_cfg(`SRC_CAP, 2'h3);
      src_cfg(`SRC_BOD, 2'h0);
      src_cfg(`SRC_WDT, 2'h0);
      fl = 14'h2006;
      last_cycle_i = 1'b1;
      wait_load(got);
      chk("source", `SRC_CAP, active_src_o);
      chk("inserv", 16'h0008, in_service_o);
      fl[`SRC_CAP] = 1'b0;
      wait_load(got);
      chk("preempt", 16'h0000, got);
      last_cycle_i = 1'b0;
      do_ret(1'b0);
      chk("inserv", 16'h0008, in_service_o);
      last_cycle_i = 1'b1;
      wait_load(got);
      chk("preempt", 16'h0000, got);
      last_cycle_i = 1'b0;
      do_ret(1'b1);
      last_cycle_i = 1'b1;
      wait_load(got);
      chk("source", `SRC_BOD, active_src_o);
      last_cycle_i = 1'b0;
      fl = 14'h0000;
      step(12);
      do_ret(1'b1);
    end
  endtask
  task t_gate;
    integer c;
    reg got;
    begin
      {be, ee, bl, bh, el, eh} = 48'h0;
      src_cfg(`SRC_SER, 2'h1);
      fl[`SRC_SER] = 1'b1;
      for (c = 0; c < 3; c = c + 1) begin
        be[7] = (c != 0);
        last_cycle_i = (c != 1);
        cfg_write_i = (c == 2);
        wait_load(got);
        chk("blocked", 16'h0000, got);
      end
      fl[`SRC_SER] = 1'b0;
      step(12);
      cfg_write_i = 1'b0;
      wait_load(got);
      chk("forgot", 16'h0000, got);
      last_cycle_i = 1'b0;
    end
  endtask
  task t_level;
    reg got;
    begin
      {be, ee, bl, bh, el, eh} = 48'h0;
      src_cfg(`SRC_EXT0, 2'h2);
      ext0_edge_mode_i = 1'b0;
      fl[0] = 1'b1;
      last_cycle_i = 1'b1;
      wait_load(got);
      chk("extflag", 16'h0001, ext0_request_flag_o);
      chk("inserv", 16'h0004, in_service_o);
      last_cycle_i = 1'b0;
      fl[0] = 1'b0;
      step(12);
      do_ret(1'b1);
      ext0_edge_mode_i = 1'b1;
    end
  endtask
  task t_wake;
    integer i;
    reg [3:0] s;
    begin
      for (i = 0; i < 28; i = i + 1) begin
        s = i % 14;
        internal_rc_oscillator_i = (i > 13);
        {be, ee, bl, bh, el, eh} = 48'h0;
        src_cfg(s, 2'h0);
        set_flag(s, 1'b1);
        step(12);
        chk("wake", WAKE[s] || (i == 19), wake_o);
        set_flag(s, 1'b0);
        step(12);
      end
    end
  endtask
  // --------------------------------------------------------------------
  // Clock, watchdog and main sequence
  // --------------------------------------------------------------------
  always #5 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      n_errors = n_errors + 1;
      conclude;
    end
  end
  initial begin
    step(20);
    nrst_i = 1'b1;
    step(1);
    chk("reset", 16'h0000, {push_o, pc_load_o, call_busy_o, wake_o,
      in_service_o, active_src_o});
    t_all;
    t_prio;
    t_gate;
    t_level;
    t_wake;
    conclude;
  end
endmodule // irq_prio_ctrl_tb
